/* File: include/seit_cfg.svh */
// constants of the serial memory target
`ifndef SEIT_CFG_SVH
`define SEIT_CFG_SVH
`define SEIT_ADDR_BITS   12
`define SEIT_PAGE_BITS   5
`define SEIT_PAGE_BYTES  32
`define SEIT_MEM_BYTES   4096
`define SEIT_ERASED      8'hFF
`define SEIT_ACK_SLOT    4'h8
`define SEIT_HI_BITS     4
`define SEIT_CLK_MHZ     200
`define SEIT_WR_TIME_US  5000
`define SEIT_WR_CYCLES   (`SEIT_WR_TIME_US * `SEIT_CLK_MHZ)
`define SEIT_CNT_BITS    20
`define SEIT_FIFO_DEPTH  8
`define SEIT_FIFO_WIDTH  13
`define SEIT_DEV_TYPE    4'h5
`endif

/* File: include/seit_pkg.sv */
// types of the serial memory target
`include "seit_cfg.svh"
package seit_pkg;
  typedef enum logic [2:0] {
    SEIT_IDLE,
    SEIT_DEV,
    SEIT_AHI,
    SEIT_ALO,
    SEIT_WDATA,
    SEIT_RDATA
  } seit_phase_t;

  typedef struct packed {
    logic [1:0]                     scl_sync;
    logic [1:0]                     sda_sync;
    logic [1:0]                     wp_sync;
    logic [2:0]                     strap_s1;
    logic [2:0]                     strap_s2;
    logic                           scl_prev;
    logic                           sda_prev;
    seit_phase_t                    phase;
    logic [3:0]                     bitcnt;
    logic                           in_ack;
    logic                           ack_given;
    logic [7:0]                     shreg;
    logic [7:0]                     txbyte;
    logic [`SEIT_HI_BITS-1:0]       addr_hi;
    logic [`SEIT_ADDR_BITS-1:0]     addr;
    logic                           wp_lat;
    logic                           pend;
    logic                           busy;
    logic [`SEIT_CNT_BITS-1:0]      busy_cnt;
    logic [`SEIT_PAGE_BITS:0]       commit_idx;
    logic [`SEIT_PAGE_BYTES-1:0]    dirty;
    logic                           sda_oe;
    logic                           sda_out;
  } seit_state_t;
endpackage

/* File: include/seit_stream_if.sv */
// valid/ready word carrier between the target and its fifo
interface seit_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: core/seit_fifo.sv */
// first-in first-out buffer, depth a power of two
module seit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic   clock,
  input wire logic   rstn,
  seit_stream_if.snk wr,
  seit_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } seit_fifo_state_t;

  seit_fifo_state_t s;
  seit_fifo_state_t next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic             full;
  logic             empty;

  assign full     = (s.wptr[AW] != s.rptr[AW]) && (s.wptr[AW-1:0] == s.rptr[AW-1:0]);
  assign empty    = (s.wptr == s.rptr);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data  = store[s.rptr[AW-1:0]];

  always_comb begin
    next_s = s;
    if (wr.valid && !full) begin
      next_s.wptr = s.wptr + 1'b1;
    end
    if (rd.ready && !empty) begin
      next_s.rptr = s.rptr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clock) begin
    if (wr.valid && !full) begin
      store[s.wptr[AW-1:0]] <= wr.data;
    end
  end
endmodule

/* File: core/seit_target.sv */
// two-wire serial memory target with page buffer and write cycle
// Function
// (R1) falling data while clock high is start
// (R2) silent and released until a start
// (R3) rising data while clock high is stop
// (R4) match type code and three strap pins
// (R5) last address bit: one read, zero write
// (R6) ninth clock carries acknowledge from receiver
// (R7) byte write: address, two offsets, data
// (R8) stop launches write cycle, then no acknowledge
// (R9) up to 32 bytes into page buffer
// (R10) page latched, offset wraps inside page
// (R11) whole page session committed in one cycle
// (R12) controller polls by repeating after no acknowledge
// (R13) protect input high blocks every write
// (R14) protect sampled on fall before first data
// (R15) protected data byte refused, write dropped
// (R16) memory starts erased, all bytes FFh
// (R17) read after start sends current address byte
// (R18) no acknowledge then stop ends read
// (R19) selected read: load address, restart, read
// (R20) keep sending while controller acknowledges
// (R21) read address wraps across whole memory
// (R22) sample on rise, change after fall, drive low
// (R23) controller keeps data steady while clock high
// (R24) open strap pins read as low
// (R25) two offset bytes form 12-bit address
module seit_target
  import seit_pkg::*;
#(
  parameter int          WR_CYCLES = `SEIT_WR_CYCLES,
  parameter logic [3:0]  DEV_TYPE  = `SEIT_DEV_TYPE  // arbitrary value
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic strap_addr_bit0,
  input  wire logic strap_addr_bit1,
  input  wire logic strap_addr_bit2,
  input  wire logic wp,
  output logic      write_busy
);
  localparam int PB = `SEIT_PAGE_BITS;
  localparam int AB = `SEIT_ADDR_BITS;
  localparam logic [`SEIT_CNT_BITS-1:0] BUSY_LAST = (`SEIT_CNT_BITS)'(WR_CYCLES - 1);
  localparam logic [PB:0] PAGE_END = (PB + 1)'(`SEIT_PAGE_BYTES);

  seit_state_t s;
  seit_state_t next_s;

  logic [7:0] mem  [`SEIT_MEM_BYTES];
  logic [7:0] pbuf [`SEIT_PAGE_BYTES];

  seit_stream_if #(.WIDTH(`SEIT_FIFO_WIDTH)) push_if ();
  seit_stream_if #(.WIDTH(`SEIT_FIFO_WIDTH)) drain_if ();

  seit_fifo #(
    .WIDTH (`SEIT_FIFO_WIDTH),
    .DEPTH (`SEIT_FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rstn  (rstn),
    .wr    (push_if.snk),
    .rd    (drain_if.src)
  );

  logic              scl_s;
  logic              sda_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_seen;
  logic              stop_seen;
  logic              push_valid;
  logic [PB+7:0]     push_data;
  logic              drain_ready;
  logic              commit_step;
  logic              commit_we;
  logic [PB-1:0]     drain_off;

  // pin levels after the two-stage synchronisers
  assign scl_s = s.scl_sync[1];
  assign sda_s = s.sda_sync[1];
  assign scl_rise   = scl_s & ~s.scl_prev;
  assign scl_fall   = ~scl_s & s.scl_prev;
  assign start_seen = scl_s & s.scl_prev & s.sda_prev & ~sda_s;  // R1
  assign stop_seen  = scl_s & s.scl_prev & ~s.sda_prev & sda_s;  // R3

  assign push_if.valid  = push_valid;
  assign push_if.data   = push_data;
  assign drain_if.ready = drain_ready;
  assign drain_off      = drain_if.data[PB+7:8];

  // the buffer is loaded only until the copy loop starts
  assign drain_ready = ~(s.busy && (s.commit_idx != '0));
  assign commit_step = s.busy && !drain_if.valid && (s.commit_idx < PAGE_END);
  assign commit_we   = commit_step && s.dirty[s.commit_idx[PB-1:0]];

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] strap);
    addr_match = (b[7:4] == DEV_TYPE) && (b[3:1] == strap);  // R4
  endfunction

  always_comb begin
    next_s     = s;
    push_valid = 1'b0;
    push_data  = {s.addr[PB-1:0], s.shreg};
    next_s.scl_sync = {s.scl_sync[0], scl};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.wp_sync  = {s.wp_sync[0], wp};
    next_s.strap_s1 = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};  // R24
    next_s.strap_s2 = s.strap_s1;
    next_s.scl_prev = scl_s;
    next_s.sda_prev = sda_s;
    next_s.sda_out  = 1'b0;  // R22

    // drained bytes mark their page slot
    if (drain_if.valid && drain_ready) begin
      next_s.dirty[drain_off] = 1'b1;  // R9
    end

    // write cycle: copy the page while busy is held for the full time
    if (s.busy) begin
      if (commit_step) begin
        next_s.commit_idx = s.commit_idx + 1'b1;  // R11
      end
      if (s.busy_cnt != BUSY_LAST) begin
        next_s.busy_cnt = s.busy_cnt + 1'b1;
      end else if (s.commit_idx == PAGE_END) begin
        next_s.busy       = 1'b0;
        next_s.commit_idx = '0;
        next_s.dirty      = '0;
      end
    end

    if (start_seen) begin
      next_s.phase  = SEIT_DEV;  // R2
      next_s.bitcnt = '0;
      next_s.in_ack = 1'b0;
      next_s.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_s.phase  = SEIT_IDLE;  // R3
      next_s.sda_oe = 1'b0;
      if (s.pend && !s.busy) begin
        next_s.busy     = 1'b1;  // R8
        next_s.busy_cnt = '0;
        next_s.pend     = 1'b0;
      end
    end else if (s.phase == SEIT_RDATA) begin
      if (scl_rise) begin
        if (s.in_ack) begin
          if (sda_s) begin
            next_s.phase  = SEIT_IDLE;  // R18
            next_s.in_ack = 1'b0;
          end else begin
            next_s.ack_given = 1'b1;  // R20
          end
        end else begin
          next_s.bitcnt = s.bitcnt + 1'b1;  // R22
        end
      end else if (scl_fall) begin
        if (s.in_ack) begin
          if (s.ack_given) begin
            next_s.txbyte    = mem[s.addr];  // R20
            next_s.sda_oe    = ~mem[s.addr][7];
            next_s.addr      = s.addr + 1'b1;  // R21
            next_s.bitcnt    = '0;
            next_s.in_ack    = 1'b0;
            next_s.ack_given = 1'b0;
          end
        end else if (s.bitcnt == `SEIT_ACK_SLOT) begin
          next_s.sda_oe = 1'b0;  // R6
          next_s.in_ack = 1'b1;
        end else if (s.bitcnt != '0) begin
          next_s.sda_oe = ~s.txbyte[3'd7 - s.bitcnt[2:0]];  // R22
        end
      end
    end else if (s.phase != SEIT_IDLE) begin
      if (scl_rise && !s.in_ack) begin
        next_s.shreg  = {s.shreg[6:0], sda_s};  // R22
        next_s.bitcnt = s.bitcnt + 1'b1;
      end else if (scl_fall && !s.in_ack && s.bitcnt == `SEIT_ACK_SLOT) begin
        next_s.in_ack = 1'b1;
        unique case (s.phase)
          SEIT_DEV: begin
            if (addr_match(s.shreg, s.strap_s2) && !s.busy) begin
              next_s.sda_oe = 1'b1;  // R6
            end else begin
              next_s.phase  = SEIT_IDLE;  // R8
              next_s.in_ack = 1'b0;
            end
          end
          SEIT_AHI: begin
            next_s.sda_oe  = 1'b1;  // R7
            next_s.addr_hi = s.shreg[`SEIT_HI_BITS-1:0];  // R25
          end
          SEIT_ALO: begin
            next_s.sda_oe = 1'b1;  // R7
            next_s.addr   = {s.addr_hi, s.shreg};  // R25
          end
          SEIT_WDATA: begin
            if (s.wp_lat || !push_if.ready) begin
              next_s.phase  = SEIT_IDLE;  // R15
              next_s.in_ack = 1'b0;
              if (s.wp_lat) begin
                next_s.pend = 1'b0;  // R13
              end
            end else begin
              next_s.sda_oe = 1'b1;  // R7
              push_valid    = 1'b1;  // R9
              next_s.pend   = 1'b1;
              next_s.addr   = {s.addr[AB-1:PB], s.addr[PB-1:0] + 1'b1};  // R10
            end
          end
          default: begin
            next_s.phase  = SEIT_IDLE;
            next_s.in_ack = 1'b0;
          end
        endcase
      end else if (scl_fall && s.in_ack) begin
        next_s.in_ack = 1'b0;
        next_s.bitcnt = '0;
        next_s.sda_oe = 1'b0;
        unique case (s.phase)
          SEIT_DEV: begin
            if (s.shreg[0]) begin
              next_s.phase  = SEIT_RDATA;  // R5
              next_s.txbyte = mem[s.addr];  // R17
              next_s.sda_oe = ~mem[s.addr][7];
              next_s.addr   = s.addr + 1'b1;  // R21
            end else begin
              next_s.phase = SEIT_AHI;  // R5
            end
          end
          SEIT_AHI: begin
            next_s.phase = SEIT_ALO;  // R19
          end
          SEIT_ALO: begin
            next_s.phase  = SEIT_WDATA;
            next_s.wp_lat = s.wp_sync[1];  // R14
            if (!s.pend) begin
              next_s.dirty = '0;
            end
          end
          SEIT_WDATA: begin
            next_s.phase = SEIT_WDATA;  // R9
          end
          default: begin
            next_s.phase = SEIT_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '{
        scl_sync : 2'h3,
        sda_sync : 2'h3,
        scl_prev : 1'b1,
        sda_prev : 1'b1,
        phase    : SEIT_IDLE,
        default  : '0
      };
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clock) begin
    if (drain_if.valid && drain_ready) begin
      pbuf[drain_off] <= drain_if.data[7:0];
    end
  end

  initial begin
    for (int i = 0; i < `SEIT_MEM_BYTES; i++) begin
      mem[i] = `SEIT_ERASED;  // R16
    end
  end

  always_ff @(posedge clock) begin
    if (commit_we) begin
      mem[{s.addr[AB-1:PB], s.commit_idx[PB-1:0]}] <= pbuf[s.commit_idx[PB-1:0]];  // R11
    end
  end

  assign sda_out    = s.sda_out;
  assign sda_oe     = s.sda_oe;
  assign write_busy = s.busy;
endmodule

/* File: tb/seit_target_sva.sv */
// pin-level assertions of the serial memory target
module seit_chk #(
  parameter int WR_CYCLES = 64
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int   busy_n;
  logic seen_start;
  logic sda_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_n     <= 0;
      seen_start <= 1'b0;
      sda_q      <= 1'b1;
    end else begin
      busy_n     <= write_busy ? busy_n + 1 : 0;
      sda_q      <= sda_in;
      seen_start <= seen_start | (scl & sda_q & ~sda_in);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_drive_low: assert property (!sda_out)
    else $error("data driven high");
  a_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("drive during write cycle");
  a_rise_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("drive began with clock high");
  a_high_stable: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("drive changed with clock high");
  a_busy_len: assert property ($fell(write_busy)
    |-> busy_n >= WR_CYCLES - 1 && busy_n <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  a_busy_stop: assert property ($rose(write_busy) |-> scl && sda_in && $past(scl, 4))
    else $error("write cycle without stop");
  a_silent_start: assert property (!seen_start |-> !sda_oe)
    else $error("drive before any start");
  a_oe_short: assert property ($rose(sda_oe) |-> ##[1:160] !sda_oe)
    else $error("data line held too long");
endmodule
bind seit_target seit_chk #(.WR_CYCLES(WR_CYCLES)) i_chk (.clock(clock), .rstn(rstn),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_busy(write_busy));

/* File: tb/seit_master.sv */
// bus controller model driving the two-wire link
module seit_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task start;
    sda_m = 1'b1;
    #20 scl = 1'b1;
    #20 sda_m = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask
  task stop;
    sda_m = 1'b0;
    #20 scl = 1'b1;
    #20 sda_m = 1'b1;
    #40;
  endtask
  task bitx(input logic b, output logic r);
    sda_m = b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
    #20;
  endtask
  task wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule

/* File: tb/test_seit_target.sv */
// self-checking bench of the serial memory target
`include "seit_cfg.svh"
module test_seit_target;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         WRC = 400;
  localparam logic [6:0] DA  = {`SEIT_DEV_TYPE, 3'b101};
  logic       clock, rstn, scl, sda_m, sda, sda_out, sda_oe, wp, write_busy, k;
  logic [2:0] strap;
  logic [7:0] d;
  logic [7:0] exp_q[$];
  int         fail_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         n;
  assign sda = sda_m & ~(sda_oe & ~sda_out);
  seit_target #(.WR_CYCLES(WRC), .DEV_TYPE(`SEIT_DEV_TYPE)) i_dut (.clock(clock),
    .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .wp(wp), .write_busy(write_busy));
  seit_master i_m (.scl(scl), .sda_m(sda_m), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task wrap_up;
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up;
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] want, input string nm);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %s want %h seen %h", nm, want, seen);
    end
  endtask
  task ak(input logic w);
    chk({7'h00, k}, {7'h00, w}, "ack");
  endtask
  task adr(input logic [11:0] a);
    i_m.start;
    i_m.wb({DA, 1'b0}, k);
    ak(1'b1);
    i_m.wb({4'hF, a[11:8]}, k);
    ak(1'b1);
    i_m.wb(a[7:0], k);
    ak(1'b1);
  endtask
  task rdq(input logic [11:0] a);
    adr(a);
    i_m.start;
    i_m.wb({DA, 1'b1}, k);
    ak(1'b1);
    foreach (exp_q[i]) begin
      i_m.rb(i == exp_q.size() - 1, d);
      chk(d, exp_q[i], "data");
    end
    i_m.stop;
    exp_q = {};
  endtask
  task wrq(input logic [11:0] a, input logic w);
    adr(a);
    foreach (exp_q[i]) begin
      i_m.wb(exp_q[i], k);
      ak(w);
    end
    i_m.stop;
    exp_q = {};
  endtask
  task poll;
    n = 0;
    do begin
      i_m.start;
      i_m.wb({DA, 1'b0}, k);
      i_m.stop;
      n++;
    end while (k !== 1'b1 && n < 50);
    chk({7'h00, n > 1}, 8'h01, "busy nack");
    chk({7'h00, k}, 8'h01, "poll end");
  endtask
  task t_erased;
    i_m.start;
    i_m.wb({DA, 1'b1}, k);
    ak(1'b1);
    i_m.rb(1'b1, d);
    chk(d, `SEIT_ERASED, "erased");
    i_m.stop;
  endtask
  task t_strap;
    for (int j = 0; j < 2; j++) begin
      i_m.start;
      i_m.wb(j ? {DA ^ 7'h01, 1'b1} : {DA ^ 7'h40, 1'b1}, k);
      ak(1'b0);
      i_m.stop;
    end
  endtask
  task t_byte;
    exp_q = {8'hA5};
    wrq(12'h123, 1'b1);
    poll;
    exp_q = {8'hA5};
    rdq(12'h123);
  endtask
  task t_page;
    int kk;
    for (int j = 0; j < 34; j++) exp_q.push_back(8'h10 + j[7:0]);
    wrq(12'h05E, 1'b1);
    poll;
    for (int o = 0; o < 32; o++) begin
      kk = (o + 2) % 32;
      if (kk < 2) kk = kk + 32;
      exp_q.push_back(8'h10 + kk[7:0]);
    end
    rdq(12'h040);
  endtask
  task t_wrap;
    exp_q = {8'h3C};
    wrq(12'h000, 1'b1);
    poll;
    exp_q = {`SEIT_ERASED, 8'h3C};
    rdq(12'hFFF);
  endtask
  task t_wp;
    wp = 1'b1;
    exp_q = {8'h77};
    wrq(12'h200, 1'b0);
    repeat (40) @(negedge clock);
    chk({7'h00, write_busy}, 8'h00, "busy");
    wp = 1'b0;
    exp_q = {`SEIT_ERASED};
    rdq(12'h200);
  endtask
  initial begin
    rstn = 1'b0;
    wp = 1'b0;
    strap = 3'b101;
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    repeat (8) @(negedge clock);
    t_erased;
    t_strap;
    t_byte;
    t_page;
    t_wrap;
    t_wp;
    wrap_up;
  end
endmodule
